/* rtl/nrw_noise_sampler.sv */
// Module: collects noise samples into random words at a bounded rate
`timescale 1ns/100ps

module nrw_noise_sampler #(
  parameter int WORD_W = nrw_pkg::RANDOM_WORD_W,
  parameter int PERIOD_CYC = nrw_pkg::WORD_PERIOD_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic run_en,          // High while the generator runs
  input wire logic noise_in,        // Digitised analog noise sample
  output logic word_valid,          // One-cycle pulse, word_out fresh
  output logic [WORD_W-1:0] word_out // Last completed word
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // A word needs at least one fresh sample per bit
  if (PERIOD_CYC < WORD_W) begin : g_bad_period
    $error("nrw_noise_sampler: PERIOD_CYC must be at least WORD_W");
  end
  if (WORD_W < 2) begin : g_bad_width
    $error("nrw_noise_sampler: WORD_W must be at least 2");
  end

  localparam int CNT_W = $clog2(PERIOD_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PERIOD_CYC - 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CNT_W-1:0] cnt;    // Cycles into the current word
    logic [WORD_W-1:0] shift; // Word being gathered
    logic [WORD_W-1:0] word;  // Last finished word
    logic valid;              // Finish pulse
  } nrw_samp_s;

  nrw_samp_s samp_ff;
  nrw_samp_s nxt_samp;

  // Gather one sample a cycle, finish a word every PERIOD_CYC cycles
  always_comb begin
    nxt_samp = samp_ff;
    nxt_samp.valid = 1'b0;
    if (run_en) begin
      // Feedback mixes older bits in so a biased source is whitened
      nxt_samp.shift = {samp_ff.shift[WORD_W-2:0], noise_in ^ samp_ff.shift[WORD_W-1] ^ samp_ff.shift[0]};
      if (samp_ff.cnt == CNT_LAST) begin
        nxt_samp.cnt = '0;
        nxt_samp.word = nxt_samp.shift;
        nxt_samp.valid = 1'b1;
      end else begin
        nxt_samp.cnt = samp_ff.cnt + CNT_W'(1);
      end
    end else begin
      nxt_samp.cnt = '0;
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      samp_ff <= '0;
    end else begin
      samp_ff <= nxt_samp;
    end
  end

  assign word_valid = samp_ff.valid;
  assign word_out = samp_ff.word;

endmodule // nrw_noise_sampler

/* rtl/nrw_pkg.sv */
// Package: register map, field positions, reset values and timing for the noise random word source
package nrw_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets on the 32-bit bus)
  // ----------------------------------------------------------------
  localparam logic [31:0] GEN_CONTROL_OFS = 32'h0000_0000; // Control word
  localparam logic [31:0] GEN_STATE_OFS = 32'h0000_0004;   // Status word
  localparam logic [31:0] RANDOM_WORD_OFS = 32'h0000_0008; // Random value

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int GENERATOR_OFF_BIT = 2;  // Control: 1 powers the generator down
  localparam int READY_BIT = 0;          // Status: fresh word held
  localparam int RANDOM_WORD_W = 16;     // Width of one random word
  localparam logic [2:0] HSIZE_WORD = 3'h2; // Only legal transfer size

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [31:0] GEN_CONTROL_RST = 32'h0000_0000; // Generator runs
  localparam logic [15:0] RANDOM_WORD_RST = 16'h0000;      // No word yet
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;       // Read bus idle value

  // ----------------------------------------------------------------
  // Timing: least spacing between two words
  // ----------------------------------------------------------------
  localparam int WORD_PERIOD_NS = 1250; // Least time between two words
  localparam int CLK_PERIOD_NS = 5;     // core_clk period
  // Least time rounds up to whole cycles
  localparam int WORD_PERIOD_CYC = (WORD_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Bus slave states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00, // Ready for an address phase
    BUS_WAIT = 2'b01, // Value read stalled for a fresh word
    BUS_ERR1 = 2'b10, // First error cycle, ready low
    BUS_ERR2 = 2'b11  // Second error cycle, ready high
  } nrw_bus_state_e;

endpackage : nrw_pkg

/* rtl/nrw_random_source.sv */
// Module: noise random word source with its three-register bus slave
`timescale 1ns/100ps

// What this block does
// - Each value read while the generator runs returns fresh 16-bit noise word
// - Only 32-bit transfers; all other sizes get error
// - Words no faster than one per 1.25 us
// - Control bit 2 high stops the generator
// - Ready flag; value reads stall until ready while generator runs, read zero at once while it is off
// - Ready stays low while generator is off
// - Word on bits 15:0, upper bits zero
// - Offsets 0x00, 0x04, 0x08; reset zero

module nrw_random_source #(
  parameter int PERIOD_CYC = nrw_pkg::WORD_PERIOD_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic noise_in,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The word rate may be slowed but never raised above the limit
  if (PERIOD_CYC < nrw_pkg::WORD_PERIOD_CYC) begin : g_bad_period
    $error("nrw_random_source: PERIOD_CYC below the least word period");
  end

  // ----------------------------------------------------------------
  // Register selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEL_CONTROL = 2'b00, // Control word
    SEL_STATE = 2'b01,   // Status word
    SEL_WORD = 2'b10,    // Random value
    SEL_NONE = 2'b11     // Unmapped
  } nrw_sel_e;

  function automatic nrw_sel_e decode_sel(input logic [31:0] addr);
    nrw_sel_e sel;
    sel = SEL_NONE;
    if (addr[7:0] == nrw_pkg::GEN_CONTROL_OFS[7:0]) begin
      sel = SEL_CONTROL;
    end else if (addr[7:0] == nrw_pkg::GEN_STATE_OFS[7:0]) begin
      sel = SEL_STATE;
    end else if (addr[7:0] == nrw_pkg::RANDOM_WORD_OFS[7:0]) begin
      sel = SEL_WORD;
    end
    return sel;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] generator_control;       // Control register, all bits kept
    logic ready;                          // Status ready flag
    logic [15:0] random_word;             // Value register contents
    nrw_pkg::nrw_bus_state_e st;          // Bus slave state
    logic wr_pend;                        // Control write in data phase
    logic [31:0] rdata;                   // Registered read data
    logic readyout;                       // Registered ready out
    logic resp;                           // Registered error response
  } nrw_src_s;

  localparam nrw_src_s SRC_RST = '{
    generator_control: nrw_pkg::GEN_CONTROL_RST,
    ready: 1'b0,
    random_word: nrw_pkg::RANDOM_WORD_RST,
    st: nrw_pkg::BUS_IDLE,
    wr_pend: 1'b0,
    rdata: nrw_pkg::RDATA_RST,
    readyout: 1'b1,
    resp: 1'b0
  };

  nrw_src_s src_ff;
  nrw_src_s nxt_src;

  // ----------------------------------------------------------------
  // Noise sampler
  // ----------------------------------------------------------------
  logic gen_run;                              // Generator powered
  logic word_valid;                           // Fresh word pulse
  logic [nrw_pkg::RANDOM_WORD_W-1:0] word_new; // Fresh word

  assign gen_run = ~src_ff.generator_control[nrw_pkg::GENERATOR_OFF_BIT];

  nrw_noise_sampler #(
    .WORD_W(nrw_pkg::RANDOM_WORD_W),
    .PERIOD_CYC(PERIOD_CYC)
  ) u_sampler (
    .core_clk(core_clk),
    .rst(rst),
    .run_en(gen_run),
    .noise_in(noise_in),
    .word_valid(word_valid),
    .word_out(word_new)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic take;          // Address phase accepted this cycle
  logic consume;       // A held word is handed out this cycle
  logic delivered_new; // Stalled read takes the fresh word
  logic run_next;      // Generator state after any control write
  nrw_sel_e sel;       // Register addressed in this address phase

  always_comb begin
    nxt_src = src_ff;
    consume = 1'b0;
    delivered_new = 1'b0;
    take = hsel & hready & htrans[1];
    sel = decode_sel(haddr);
    // Default answer: ready, okay
    nxt_src.st = nrw_pkg::BUS_IDLE;
    nxt_src.readyout = 1'b1;
    nxt_src.resp = 1'b0;

    // Control write lands in its data phase, forwarded to reads below
    nxt_src.wr_pend = 1'b0;
    if (src_ff.wr_pend) begin
      nxt_src.generator_control = hwdata;
    end
    run_next = ~nxt_src.generator_control[nrw_pkg::GENERATOR_OFF_BIT];

    case (src_ff.st)
      nrw_pkg::BUS_ERR1: begin
        nxt_src.st = nrw_pkg::BUS_ERR2;
        nxt_src.resp = 1'b1;
      end
      nrw_pkg::BUS_WAIT: begin
        if (word_valid && gen_run) begin
          nxt_src.rdata = {16'h0000, word_new};
          delivered_new = 1'b1;
        end else if (!run_next) begin
          // Generator stopped: end the stall rather than hang the bus
          nxt_src.rdata = 32'h0000_0000;
        end else begin
          nxt_src.st = nrw_pkg::BUS_WAIT;
          nxt_src.readyout = 1'b0;
        end
      end
      nrw_pkg::BUS_IDLE, nrw_pkg::BUS_ERR2: begin
        if (take) begin
          if (hsize != nrw_pkg::HSIZE_WORD) begin
            nxt_src.st = nrw_pkg::BUS_ERR1;
            nxt_src.readyout = 1'b0;
            nxt_src.resp = 1'b1;
          end else if (hwrite) begin
            // Only the control register takes writes
            nxt_src.wr_pend = (sel == SEL_CONTROL);
          end else begin
            case (sel)
              SEL_CONTROL: begin
                nxt_src.rdata = nxt_src.generator_control;
              end
              SEL_STATE: begin
                nxt_src.rdata = 32'h0000_0000;
                nxt_src.rdata[nrw_pkg::READY_BIT] = src_ff.ready;
              end
              SEL_WORD: begin
                if (src_ff.ready) begin
                  nxt_src.rdata = {16'h0000, src_ff.random_word};
                  consume = 1'b1;
                end else if (run_next) begin
                  nxt_src.st = nrw_pkg::BUS_WAIT;
                  nxt_src.readyout = 1'b0;
                end else begin
                  // Disabled and empty: answer zero at once
                  nxt_src.rdata = 32'h0000_0000;
                end
              end
              default: begin
                // Unmapped address reads zero
                nxt_src.rdata = 32'h0000_0000;
              end
            endcase
          end
        end
      end
      default: begin
        nxt_src.st = nrw_pkg::BUS_IDLE;
      end
    endcase

    if (consume) begin
      nxt_src.ready = 1'b0;
    end
    // Fresh word sets ready; set wins over a same-cycle consume, not over generator off
    if (word_valid && gen_run) begin
      nxt_src.random_word = word_new;
      nxt_src.ready = ~delivered_new;
    end
    if (!gen_run || !run_next) begin
      nxt_src.ready = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // everything resets to zero except readyout, which resets high; generator enabled
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      src_ff <= SRC_RST;
    end else begin
      src_ff <= nxt_src;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, straight from flip-flops
  // ----------------------------------------------------------------
  assign hreadyout = src_ff.readyout;
  assign hresp = src_ff.resp;
  assign hrdata = src_ff.rdata;

endmodule // nrw_random_source

/* tb/nrw_ahb_host.sv */
// Partner: host processor issuing single bus transfers
`timescale 1ns/100ps
module nrw_ahb_host (
  input wire logic core_clk,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // Idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // One transfer; released lines show inverted values so stale data is never reused
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [2:0] sz, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err, output int nw);
    nw = 0;
    @(negedge core_clk);
    // Address phase only once the slave shows ready, so it is taken at the next edge
    while (hreadyout !== 1'b1) @(negedge core_clk);
    hsel = 1'b1;
    haddr = a;
    htrans = 2'h2;
    hwrite = wr;
    hsize = sz;
    @(posedge core_clk);
    @(negedge core_clk);
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = ~a;
    hwrite = ~wr;
    hsize = ~sz;
    hwdata = wr ? wd : ~hwdata;
    // Bounded wait; ready and data are read settled, half a cycle before the edge that samples them
    nw = 1;
    while (hreadyout !== 1'b1 && nw < 1000) begin
      @(negedge core_clk);
      nw++;
    end
    // Answer still stands at the closing edge; nothing changes before it
    rd = hrdata;
    err = hresp;
  endtask
endmodule // nrw_ahb_host

/* tb/nrw_random_source_sva.sv */
// Checker: bus answers and register rules of the random word source
`timescale 1ns/100ps
module nrw_random_source_sva #(
  parameter int PERIOD_CYC = nrw_pkg::WORD_PERIOD_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic noise_in,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata
);
  // ----------------------------------------------------------
  // Data phase shadow
  // ----------------------------------------------------------
  logic take; // Address phase taken
  logic done; // Legal data phase ends
  logic arr; // Stalled value read ends, a word just arrived
  logic dp_v_ff, dp_wr_ff, dp_ok_ff, stl_ff, rdy_ff;
  logic [7:0] dp_a_ff;
  logic [31:0] ctrl_ff; // Expected control word
  int unsigned gap_ff, wait_ff;
  assign take = hsel && hready && htrans[1];
  assign done = dp_v_ff && hreadyout && dp_ok_ff;
  assign arr = done && !dp_wr_ff && dp_a_ff == 8'h08 && stl_ff;

  // Shadow state; gap starts full so the first word is free
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dp_v_ff <= 1'b0;
      dp_wr_ff <= 1'b0;
      dp_ok_ff <= 1'b0;
      dp_a_ff <= 8'h00;
      stl_ff <= 1'b0;
      rdy_ff <= 1'b0;
      ctrl_ff <= 32'h0000_0000;
      gap_ff <= PERIOD_CYC;
      wait_ff <= 0;
    end else begin
      if (hready) begin
        dp_v_ff <= take;
        dp_wr_ff <= hwrite;
        dp_ok_ff <= (hsize == nrw_pkg::HSIZE_WORD);
        dp_a_ff <= haddr[7:0];
      end
      stl_ff <= dp_v_ff && !hreadyout;
      wait_ff <= (dp_v_ff && !hreadyout) ? wait_ff + 1 : 0;
      gap_ff <= arr ? 0 : gap_ff + 1;
      if (done && !dp_wr_ff && dp_a_ff == 8'h04)
        rdy_ff <= hrdata[0];
      else if (done && (dp_a_ff == 8'h08 || dp_a_ff == 8'h00))
        rdy_ff <= 1'b0;
      if (done && dp_wr_ff && dp_a_ff == 8'h00)
        ctrl_ff <= hwdata;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  AST_ERR_SEQ: assert property (take && hsize != nrw_pkg::HSIZE_WORD |=> !hreadyout && hresp ##1 hreadyout && hresp)
    else $error("narrow transfer without two-cycle error");
  AST_OKAY_WORD: assert property (done |-> !hresp)
    else $error("word transfer answered with error");
  AST_UPPER_ZERO: assert property (done && !dp_wr_ff && dp_a_ff == 8'h08 |-> hrdata[31:16] == 16'h0000)
    else $error("value upper half not zero");
  AST_STATUS_RSV: assert property (done && !dp_wr_ff && dp_a_ff == 8'h04 |-> hrdata[31:1] == 31'h0)
    else $error("status reserved bits set");
  AST_CTRL_READ: assert property (done && !dp_wr_ff && dp_a_ff == 8'h00 |-> hrdata == ctrl_ff)
    else $error("control readback wrong");
  AST_OFF_NOT_READY: assert property (done && !dp_wr_ff && dp_a_ff == 8'h04 && ctrl_ff[2] |-> !hrdata[0])
    else $error("ready while generator off");
  AST_STALL_BOUND: assert property (wait_ff <= PERIOD_CYC + 2)
    else $error("value read stalled too long");
  AST_WORD_SPACING: assert property (arr |-> gap_ff >= PERIOD_CYC - 1)
    else $error("words closer than one period");
  AST_READY_NO_STALL: assert property (dp_v_ff && dp_ok_ff && !dp_wr_ff && dp_a_ff == 8'h08 && rdy_ff |-> hreadyout)
    else $error("value read stalled while ready");
  AST_UNMAPPED_ZERO: assert property (done && !dp_wr_ff && !(dp_a_ff inside {8'h00, 8'h04, 8'h08}) |-> hrdata == 32'h0)
    else $error("unmapped read not zero");

  // Main scenarios reached
  cover property (take && hsize != nrw_pkg::HSIZE_WORD);
  cover property (arr);
  cover property (done && !dp_wr_ff && dp_a_ff == 8'h04 && hrdata[0]);
endmodule // nrw_random_source_sva

bind nrw_random_source nrw_random_source_sva #(.PERIOD_CYC(PERIOD_CYC)) chk (.core_clk, .rst, .noise_in, .hsel, .haddr,
  .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata);

/* tb/nrw_random_source_tb.sv */
// Testbench: random word source against a rule-based model
`timescale 1ns/100ps
module nrw_random_source_tb;
  localparam int P = 250; // Word spacing in cycles
  localparam logic [2:0] SZ[4] = '{3'h0, 3'h1, 3'h3, 3'h4}; // Refused sizes
  localparam logic [31:0] RO[5] = '{32'h4, 32'h8, 32'hC, 32'h10, 32'hFC}; // No writable place
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic noise_in = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, err;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] ctrl_m = 32'h0; // Model of the control word
  logic [15:0] words[$]; // Words delivered so far
  int nw;
  int err_count = 0;
  int n_checks = 0;
  time t0;

  always #2.5 core_clk = ~core_clk;

  nrw_random_source #(.PERIOD_CYC(P)) uut (.core_clk, .rst, .noise_in, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata);
  nrw_ahb_host host (.core_clk, .hreadyout, .hresp, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);

  // ----------------------------------------------------------
  // Compare and access tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int v, input int lo, input int hi);
    n_checks++;
    if (v < lo || v > hi) begin
      err_count++;
      $display("[ERR] %0t count %0d outside %0d..%0d", $time, v, lo, hi);
    end
  endtask
  task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    host.xfer(wr, a, 3'h2, wd, rd, err, nw);
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, err}, 32'h0);
  endtask
  // Value read: wait count in range, upper half zero, word new
  task automatic rd_word(input int lo, input int hi);
    acc(1'b0, 32'h8, 32'h0);
    chk_rng(nw, lo, hi);
    chk({16'h0, rd[15:0]}, rd);
    if (words.size() > 0) chk({31'h0, rd[15:0] == words[$]}, 32'h0);
    words.push_back(rd[15:0]);
  endtask
  task automatic test_done;
    if (err_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog, some four times the expected run
  initial begin
    #50000;
    err_count++;
    test_done;
  end

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    void'($urandom(32'h1196580c));
    fork
      forever @(negedge core_clk) noise_in <= 1'($urandom);
    join_none
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    rd_chk(32'h0, 32'h0);
    rd_chk(32'h4, 32'h0);
    // Sizes other than 32-bit refused, no effect
    foreach (SZ[i]) begin
      host.xfer(1'b1, 32'h0, SZ[i], 32'h4, rd, err, nw);
      chk({31'h0, err}, 32'h1);
    end
    rd_chk(32'h0, 32'h0);
    // Control round trip, generator kept running
    repeat (4) begin
      ctrl_m = $urandom & 32'hFFFF_FFFB;
      acc(1'b1, 32'h0, ctrl_m);
      rd_chk(32'h0, ctrl_m);
    end
    // Writes elsewhere dropped, unmapped reads zero
    foreach (RO[i]) begin
      acc(1'b1, RO[i], $urandom);
      rd_chk(32'h0, ctrl_m);
      if (RO[i] > 32'h8) rd_chk(RO[i], 32'h0);
    end
    // Back-to-back stalled reads, one word per period
    rd_word(2, P + 1);
    repeat (3) rd_word(P - 3, P + 1);
    rd_chk(32'h4, 32'h0);
    // Word waiting: shown in status, read without stall
    repeat (P + 10) @(negedge core_clk);
    rd_chk(32'h4, 32'h1);
    rd_word(1, 1);
    rd_chk(32'h4, 32'h0);
    // Generator off: ready stays low
    acc(1'b1, 32'h0, 32'h4);
    repeat (2 * P) @(negedge core_clk);
    rd_chk(32'h4, 32'h0);
    rd_chk(32'h0, 32'h4);
    rd_chk(32'h8, 32'h0);
    // Back on: first word one period later
    acc(1'b1, 32'h0, 32'h0);
    t0 = $time;
    do acc(1'b0, 32'h4, 32'h0); while (rd[0] !== 1'b1 && $time - t0 < 10 * P);
    chk_rng(int'(($time - t0) / 5), P - 4, P + 8);
    rd_word(1, 1);
    // Reset in mid-run clears control and ready
    acc(1'b1, 32'h0, 32'h3);
    repeat (P + 10) @(negedge core_clk);
    rst = 1'b1;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    rd_chk(32'h0, 32'h0);
    rd_chk(32'h4, 32'h0);
    test_done;
  end
endmodule // nrw_random_source_tb
